// *** pprs_glitch_filter.sv ***
// Reset glitch filter: passes a low only once it outlasts the filter width.
// Assumes raw_n already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
`include "pprs_map.svh"
module pprs_glitch_filter
#(
  parameter int WIDTH_CYC = `PPRS_GLITCH_CYC
)
(
  input  wire logic clk,
  input  wire logic reset_n,
  pprs_if.filt      fl
);
  import pprs_pkg::*;
  initial
  begin
    if (WIDTH_CYC < 1 || WIDTH_CYC > 65534)
      $error("Glitch width outside the counter range");
  end

  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        clean_ff;
  logic        nxt_clean;

  always_comb
  begin
    nxt_cnt   = cnt_ff;
    nxt_clean = clean_ff;
    if (fl.raw_n)
    begin
      nxt_cnt   = 16'h0000;
      nxt_clean = 1'b1;
    end
    else if (cnt_ff > 16'(WIDTH_CYC))
      nxt_clean = 1'b0;
    else
      nxt_cnt = cnt_ff + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt_ff   <= 16'h0000;
      clean_ff <= 1'b1;
    end
    else
    begin
      cnt_ff   <= nxt_cnt;
      clean_ff <= nxt_clean;
    end
  end

  assign fl.clean_n = clean_ff;

  // Short lows never reach the output
  a_glitch_short: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(clean_ff) |-> !$past(fl.raw_n) &&
      $past(cnt_ff) == 16'(WIDTH_CYC + 1))
    else $error("Filter passed a short low");
endmodule
`default_nettype wire

// *** pprs_host.sv ***
// Host model: panel reset, standby, link clock and frame marks.
// Assumes tb calls its tasks; pins other than link_clk move 1 ns after clk rises.
`timescale 1ns/1ps
`default_nettype none
module pprs_host
(
  input  wire logic clk,
  output logic      panel_reset_n,
  output logic      standby_n,
  output logic      link_clk,
  output logic      frame_start
);
  logic run;
  initial
  begin
    panel_reset_n = 1'b1;
    standby_n     = 1'b0;
    link_clk      = 1'b0;
    frame_start   = 1'b0;
    run           = 1'b0;
  end
  // Uneven halves mimic spread; clock parks low when stopped
  always
  begin
    wait (run);
    #155 link_clk = 1'b1;
    #165 link_clk = 1'b0;
  end
  // Frames counted here, no outside timer
  task automatic frames(input int n);
    repeat (n)
    begin
      @(posedge clk) #1 frame_start = 1'b1;
      repeat (4) @(posedge clk);
      #1 frame_start = 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  task automatic pins(input logic r, input logic s, input logic l);
    @(posedge clk) #1;
    panel_reset_n = r;
    standby_n = s;
    run = l;
  endtask
endmodule
`default_nettype wire

// *** pprs_if.sv ***
// Interface between sequencer and its reset glitch filter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface pprs_if;
  logic raw_n;
  logic clean_n;
  modport filt (input raw_n, output clean_n);
  modport seq  (output raw_n, input clean_n);
endinterface
`default_nettype wire

// *** pprs_map.svh ***
// Constants for the panel power and reset sequencer.
// Assumes a 25 MHz core clock; frame starts arrive as pin-level events.
// How it works
// - Panel reset low holds the sequencer in reset; high lets it run.
// - Standby low turns timing controller, buffers, DAC and power circuit off.
// - After standby rises, ten incoming frames of power step-up precede display.
// - Between standby entry and link stop, panel residual charge is discharged.
// - Reset low pulses up to 100 us are glitches and are ignored.
// - Link clock may spread +/-3 percent; receiving stays correct.
`ifndef PPRS_MAP_SVH
`define PPRS_MAP_SVH
`define PPRS_CLK_MHZ         25
`define PPRS_GLITCH_US       100
`define PPRS_GLITCH_CYC      (`PPRS_GLITCH_US * `PPRS_CLK_MHZ)
`define PPRS_STEP_FRAMES     10
`define PPRS_DISCH_FRAMES    10
`define PPRS_LINK_IDLE_CYC   64
`endif

// *** pprs_pkg.sv ***
// Types for the panel power and reset sequencer.
// Assumes pprs_map.svh supplies all numbers.
package pprs_pkg;
  typedef enum logic [2:0]
  {
    PPRS_RESET,
    PPRS_OFF,
    PPRS_STEP_UP,
    PPRS_DISPLAY,
    PPRS_DISCHARGE
  } pprs_state_t;
endpackage

// *** pprs_top.sv ***
// Panel power and reset sequencer top.
// Assumes pins asynchronous to clk; link clock sampled, frame_start is a
// pin-level frame marker from the receiver.
`timescale 1ns/1ps
`default_nettype none
`include "pprs_map.svh"
module pprs_top
#(
  parameter int GLITCH_CYC  = `PPRS_GLITCH_CYC,
  parameter int STEP_FRAMES = `PPRS_STEP_FRAMES,
  parameter int DISCH_FRAMES = `PPRS_DISCH_FRAMES,
  parameter int IDLE_CYC    = `PPRS_LINK_IDLE_CYC
)
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          panel_reset_n,
  input  wire logic          standby_n,
  input  wire logic          link_clk,
  input  wire logic          frame_start,
  output logic               power_on,
  output logic               display_en,
  output logic               discharge_en,
  output logic               link_active,
  output pprs_pkg::pprs_state_t state
);
  import pprs_pkg::*;
  initial
  begin
    if (STEP_FRAMES < 1 || STEP_FRAMES > 255 || DISCH_FRAMES < 1 ||
        DISCH_FRAMES > 255 || IDLE_CYC < 2 || IDLE_CYC > 255)
      $error("Unsupported sequencer parameter");
  end

  // Two-stage synchronisers; first stage read by second only
  logic [1:0] rst_s_ff;
  logic [1:0] stb_s_ff;
  logic [1:0] lck_s_ff;
  logic [1:0] frm_s_ff;
  logic       lck_d_ff;
  logic       frm_d_ff;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rst_s_ff <= 2'h3; // Idle high, so no false reset follows
      stb_s_ff <= 2'h0;
      lck_s_ff <= 2'h0;
      frm_s_ff <= 2'h0;
      lck_d_ff <= 1'b0;
      frm_d_ff <= 1'b0;
    end
    else
    begin
      rst_s_ff <= {rst_s_ff[0], panel_reset_n};
      stb_s_ff <= {stb_s_ff[0], standby_n};
      lck_s_ff <= {lck_s_ff[0], link_clk};
      frm_s_ff <= {frm_s_ff[0], frame_start};
      lck_d_ff <= lck_s_ff[1];
      frm_d_ff <= frm_s_ff[1];
    end
  end

  logic lck_edge;
  logic frm_edge;
  assign lck_edge = lck_s_ff[1] & ~lck_d_ff;
  assign frm_edge = frm_s_ff[1] & ~frm_d_ff;

  pprs_if rif();
  assign rif.raw_n = rst_s_ff[1];

  pprs_glitch_filter #(.WIDTH_CYC(GLITCH_CYC)) u_filt
  (
    .clk     (clk),
    .reset_n (reset_n),
    .fl      (rif.filt)
  );

  // Link activity watchdog; tolerant of spread clocks since only edges count
  logic [7:0] idle_ff;
  logic [7:0] nxt_idle;
  logic       act_ff;
  logic       nxt_act;

  always_comb
  begin
    nxt_idle = idle_ff;
    nxt_act  = act_ff;
    if (lck_edge)
    begin
      nxt_idle = 8'h00;
      nxt_act  = 1'b1;
    end
    else if (idle_ff >= 8'(IDLE_CYC))
      nxt_act = 1'b0;
    else
      nxt_idle = idle_ff + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      idle_ff <= 8'h00;
      act_ff  <= 1'b0;
    end
    else
    begin
      idle_ff <= nxt_idle;
      act_ff  <= nxt_act;
    end
  end

  // Main sequence
  pprs_state_t st_ff;
  pprs_state_t nxt_st;
  logic [7:0]  frm_ff;
  logic [7:0]  nxt_frm;

  always_comb
  begin
    nxt_st  = st_ff;
    nxt_frm = frm_ff;
    if (!rif.clean_n)
    begin
      nxt_st  = PPRS_RESET;
      nxt_frm = 8'h00;
    end
    else
    begin
      case (st_ff)
        PPRS_RESET:
        begin
          nxt_st = PPRS_OFF;
        end
        PPRS_OFF:
        begin
          if (stb_s_ff[1])
          begin
            nxt_st  = PPRS_STEP_UP;
            nxt_frm = 8'h00;
          end
        end
        PPRS_STEP_UP:
        begin
          if (!stb_s_ff[1])
          begin
            nxt_st  = PPRS_DISCHARGE;
            nxt_frm = 8'h00;
          end
          else if (frm_edge && act_ff)
          begin
            if (frm_ff == 8'(STEP_FRAMES - 1))
              nxt_st = PPRS_DISPLAY;
            else
              nxt_frm = frm_ff + 8'h01;
          end
        end
        PPRS_DISPLAY:
        begin
          if (!stb_s_ff[1])
          begin
            nxt_st  = PPRS_DISCHARGE;
            nxt_frm = 8'h00;
          end
        end
        PPRS_DISCHARGE:
        begin
          // Host keeps frames flowing here; only reset, standby high or a dead link ends discharge, the frame count ends nothing
          if (stb_s_ff[1])
          begin
            nxt_st  = PPRS_STEP_UP;
            nxt_frm = 8'h00;
          end
          else if (!act_ff)
            nxt_st = PPRS_OFF;
          else if (frm_edge && frm_ff != 8'(DISCH_FRAMES))
            nxt_frm = frm_ff + 8'h01;
        end
        default:
        begin
          nxt_st = PPRS_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_ff  <= PPRS_RESET;
      frm_ff <= 8'h00;
    end
    else
    begin
      st_ff  <= nxt_st;
      frm_ff <= nxt_frm;
    end
  end

  // Registered outputs
  logic pwr_ff;
  logic disp_ff;
  logic dis_ff;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pwr_ff  <= 1'b0;
      disp_ff <= 1'b0;
      dis_ff  <= 1'b0;
    end
    else
    begin
      pwr_ff  <= (nxt_st == PPRS_STEP_UP) || (nxt_st == PPRS_DISPLAY);
      disp_ff <= (nxt_st == PPRS_DISPLAY);
      dis_ff  <= (nxt_st == PPRS_DISCHARGE);
    end
  end

  assign power_on     = pwr_ff;
  assign display_en   = disp_ff;
  assign discharge_en = dis_ff;
  assign link_active  = act_ff;
  assign state        = st_ff;

  a_standby_off: assert property (@(posedge clk) disable iff (!reset_n)
    (!stb_s_ff[1] && st_ff != PPRS_STEP_UP && st_ff != PPRS_DISPLAY)
      |=> !power_on)
    else $error("Power on while in standby");

  a_reset_holds: assert property (@(posedge clk) disable iff (!reset_n)
    !rif.clean_n |=> st_ff == PPRS_RESET ##1 !power_on)
    else $error("Reset did not hold sequencer");

  a_step_count: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == PPRS_STEP_UP && nxt_st == PPRS_DISPLAY)
      |-> frm_ff == 8'(STEP_FRAMES - 1) && frm_edge)
    else $error("Display before step-up frames");

  a_disch_entry: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == PPRS_DISPLAY && !stb_s_ff[1] && rif.clean_n)
      |=> st_ff == PPRS_DISCHARGE && discharge_en)
    else $error("No discharge after standby");

  a_link_idle: assert property (@(posedge clk) disable iff (!reset_n)
    lck_edge |=> link_active)
    else $error("Link edge not seen");
endmodule
`default_nettype wire

// *** tb.sv ***
// Testbench for the panel power and reset sequencer.
// Assumes short counts via parameters; host model drives all pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pprs_pkg::*;
  localparam int GC = 20;
  localparam int SF = 3;
  localparam int IC = 64;
  logic        clk;
  logic        reset_n;
  logic        prst_n;
  logic        standby_select_n_n;
  logic        lclk;
  logic        fs;
  logic        pwr;
  logic        disp;
  logic        dis;
  logic        lact;
  pprs_state_t state;
  int          n_mismatch;
  int          checks_done;
  pprs_host host (.clk(clk), .panel_reset_n(prst_n), .standby_n(standby_select_n_n),
    .link_clk(lclk), .frame_start(fs));
  pprs_top #(.GLITCH_CYC(GC), .STEP_FRAMES(SF), .DISCH_FRAMES(SF),
    .IDLE_CYC(IC)) dut (.clk(clk), .reset_n(reset_n),
    .panel_reset_n(prst_n), .standby_n(standby_select_n_n), .link_clk(lclk),
    .frame_start(fs), .power_on(pwr), .display_en(disp),
    .discharge_en(dis), .link_active(lact), .state(state));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [2:0] e,
    input logic [2:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_st(input pprs_state_t s, input int mx);
    @(negedge clk);
    for (int i = 0; i < mx && state !== s; i++)
      @(negedge clk);
    chk("state", s, state);
  endtask
  task automatic outs(input logic [2:0] e);
    @(negedge clk);
    chk("outputs", e, {pwr, disp, dis});
  endtask
  task automatic t_power_up;
    host.pins(1'b1, 1'b1, 1'b1);
    wait_st(PPRS_STEP_UP, 10);
    outs(3'h4);
    repeat (16) @(posedge clk);
    host.frames(SF - 1);
    @(negedge clk);
    chk("state", PPRS_STEP_UP, state);
    chk("link", 1'b1, lact);
    host.frames(1);
    wait_st(PPRS_DISPLAY, 10);
    outs(3'h6);
  endtask
  task automatic t_glitch;
    host.pins(1'b0, 1'b1, 1'b1);
    repeat (GC / 2) @(posedge clk);
    host.pins(1'b1, 1'b1, 1'b1);
    repeat (GC) @(negedge clk);
    chk("state", PPRS_DISPLAY, state);
  endtask
  task automatic t_power_down;
    host.pins(1'b1, 1'b0, 1'b1);
    wait_st(PPRS_DISCHARGE, 10);
    outs(3'h1);
    host.frames(SF);
    @(negedge clk);
    chk("state", PPRS_DISCHARGE, state);
    host.pins(1'b1, 1'b0, 1'b0);
    wait_st(PPRS_OFF, IC + 20);
    outs(3'h0);
    chk("link", 1'b0, lact);
  endtask
  task automatic t_hard_reset;
    t_power_up();
    host.pins(1'b0, 1'b1, 1'b1);
    wait_st(PPRS_RESET, GC + 20);
    outs(3'h0);
    host.pins(1'b1, 1'b0, 1'b0);
    wait_st(PPRS_OFF, IC + 20);
  endtask
  // Standby toggles mid step-up and mid discharge; frames without link
  task automatic t_restep;
    host.pins(1'b1, 1'b1, 1'b1);
    wait_st(PPRS_STEP_UP, 10);
    repeat (16) @(posedge clk);
    host.pins(1'b1, 1'b0, 1'b1);
    wait_st(PPRS_DISCHARGE, 10);
    host.pins(1'b1, 1'b1, 1'b1);
    wait_st(PPRS_STEP_UP, 10);
    outs(3'h4);
    host.pins(1'b1, 1'b1, 1'b0);
    repeat (IC + 16) @(posedge clk);
    @(negedge clk);
    chk("link", 1'b0, lact);
    host.frames(SF);
    @(negedge clk);
    chk("state", PPRS_STEP_UP, state);
    host.pins(1'b1, 1'b0, 1'b0);
    wait_st(PPRS_OFF, 10);
    outs(3'h0);
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    n_mismatch = 0;
    checks_done = 0;
    reset_n = 1'b0;
    repeat (20) @(posedge clk);
    #1 reset_n = 1'b1;
    wait_st(PPRS_OFF, 10);
    outs(3'h0);
    t_power_up();
    t_glitch();
    t_power_down();
    t_hard_reset();
    t_restep();
    final_report();
  end
  // Whole run needs well under 2000 cycles
  initial
  begin
    #2000000;
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
